/* File: include/led_pkg.sv */
package led_pkg;

  // =====================================================================
  // sizes
  localparam int NUM_SINKS    = 5;
  localparam int NUM_BANKS    = 4;
  localparam int NUM_PATTERNS = 4;
  localparam int NUM_ZONES    = 5;
  localparam int NUM_BOUNDS   = 4;
  localparam int CODE_W       = 8;
  localparam int FS_W         = 5;
  localparam int FRAC_W       = 16;
  localparam int ZONE_W       = 3;
  localparam int SEL_W        = 3;
  localparam int STEP_W       = 12;

  // =====================================================================
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int RAMP_STEP_NS [8] = '{50, 1000, 2000, 4000,
                                      8000, 16000, 32000, 64000};
  localparam int DUTY_SHIFT_DEF = 8;
  localparam int DUTY_FULL      = 255;

  // =====================================================================
  // reset values and codes
  localparam logic [CODE_W-1:0] CODE_ZERO   = 8'h00;
  localparam logic [CODE_W-1:0] DUTY_RESET  = 8'hff;
  localparam logic [CODE_W-1:0] DUTY_MAX    = 8'hff;
  localparam logic [FRAC_W-1:0] LIN_MULT    = 16'h0101;
  localparam logic [FRAC_W-1:0] FRAC_ZERO   = 16'h0000;
  localparam logic [ZONE_W-1:0] ZONE_RESET  = 3'h0;
  localparam logic [ZONE_W-1:0] ZONE_TOP    = 3'h4;
  localparam logic [STEP_W-1:0] STEP_ZERO   = 12'h000;

  // =====================================================================
  // exponential transfer
  localparam real EXP_BASE = 0.862;
  localparam real EXP_GAIN = 46.6;
  localparam real EXP_DIV  = 5.5;

  typedef logic [FRAC_W-1:0] exp_lut_t [256];

  function automatic exp_lut_t build_exp_lut();
    exp_lut_t t;
    for (int i = 0; i < 256; i++) begin
      t[i] = FRAC_W'($rtoi(65535.0 *
             (EXP_BASE ** (EXP_GAIN * (i + 1) / EXP_DIV))));
    end
    return t;
  endfunction : build_exp_lut

  localparam exp_lut_t EXP_LUT = build_exp_lut();

  function automatic logic [STEP_W-1:0] ramp_step_cycles(
    input logic [SEL_W-1:0] sel);
    int c;
    c = RAMP_STEP_NS[sel] / CLK_PERIOD_NS;
    if (c < 1) begin
      c = 1;
    end
    return STEP_W'(c);
  endfunction : ramp_step_cycles

  typedef enum logic [3:0] {
    RAMP_OFF   = 4'h1,
    RAMP_START = 4'h2,
    RAMP_RUN   = 4'h4,
    RAMP_STOP  = 4'h8
  } ramp_state_e;

endpackage : led_pkg

/* File: include/ramp_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface ramp_if;
  import led_pkg::*;
  logic              enable;
  logic [CODE_W-1:0] target;
  logic [SEL_W-1:0]  start_sel;
  logic [SEL_W-1:0]  stop_sel;
  logic [SEL_W-1:0]  up_sel;
  logic [SEL_W-1:0]  down_sel;
  logic [CODE_W-1:0] code;
  logic              active;

  modport ctrl (output enable, target, start_sel, stop_sel, up_sel,
                output down_sel, input code, active);
  modport ramp (input enable, target, start_sel, stop_sel, up_sel,
                input down_sel, output code, active);
endinterface : ramp_if
`default_nettype wire

/* File: design/ramp_unit.sv */
`timescale 1ns/10ps
`default_nettype none
module ramp_unit
  import led_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic arst_n,
  ramp_if.ramp      rif
);

  // =====================================================================
  // ramp state
  ramp_state_e       state_reg;
  ramp_state_e       state_next;
  logic [CODE_W-1:0] code_reg;
  logic [CODE_W-1:0] code_next;
  logic [STEP_W-1:0] cnt_reg;
  logic [STEP_W-1:0] cnt_next;

  wire               going_off = (state_reg == RAMP_STOP) ||
                                 (state_reg == RAMP_OFF);
  wire [CODE_W-1:0]  goal      = going_off ? CODE_ZERO : rif.target;
  wire [SEL_W-1:0]   sel       = (state_reg == RAMP_START) ? rif.start_sel :
                                 (state_reg == RAMP_STOP) ? rif.stop_sel :
                                 (code_reg < goal) ? rif.up_sel :
                                 rif.down_sel;
  wire [STEP_W-1:0]  interval  = ramp_step_cycles(sel);
  wire               tick      = cnt_reg >= (interval - STEP_W'(1));
  wire               at_goal   = code_reg == goal;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      RAMP_OFF:   if (rif.enable) state_next = RAMP_START;
      RAMP_START: begin
        if (!rif.enable) state_next = RAMP_STOP;
        else if (at_goal) state_next = RAMP_RUN;
      end
      RAMP_RUN:   if (!rif.enable) state_next = RAMP_STOP;
      RAMP_STOP:  begin
        if (rif.enable) state_next = RAMP_START;
        else if (at_goal) state_next = RAMP_OFF;
      end
    endcase
  end

  // one code step per interval toward the goal
  always_comb begin
    code_next = code_reg;
    cnt_next  = (tick || at_goal) ? STEP_ZERO : cnt_reg + STEP_W'(1);
    if (tick && !at_goal) begin
      code_next = (code_reg < goal) ? code_reg + CODE_W'(1)
                                    : code_reg - CODE_W'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= RAMP_OFF;
      code_reg  <= CODE_ZERO;
      cnt_reg   <= STEP_ZERO;
    end else begin
      state_reg <= state_next;
      code_reg  <= code_next;
      cnt_reg   <= cnt_next;
    end
  end

  assign rif.code   = code_reg;
  assign rif.active = state_reg != RAMP_OFF;

endmodule : ramp_unit
`default_nettype wire

/* File: design/led_brightness_control.sv */
// Function
// - each bank has an 8-bit brightness and 5-bit full-scale setting
// - any of four pattern generators can blink a sink's current
// - any sink can be assigned to any of the four banks
// - sink current from bank code, PWM, ambient light or a mix
// - per-sink anode bit, default 1, puts sink in pump gain loop
// - anode bits decide how the shorted-string fault flag rises
// - each bank picks exponential or linear code-to-current transfer
// - exponential: full scale times 0.862^(46.6(code+1)/5.5) times duty
// - linear: full scale times code/255 times duty
// - eight start-up and eight shutdown times, global to all banks
// - start-up ramps to set point, shutdown ramps to zero
// - level changes ramp with global up-time and down-time choices
// - brightness register sets bank current, scaled by duty if enabled
// - PWM scales current linearly, full duty gives code times scale
// - polarity setting makes PWM active low, low time counts
// - five ambient zones with three target sets
// - four upper and four lower 8-bit zone boundaries, 7.843 mV step
// - zone rises above upper boundary, falls below lower boundary
// - light voltage arrives as 8-bit code, 0xff equals 2 V
// - targets are 8-bit; first set bank one only, others assignable
`timescale 1ns/10ps
`default_nettype none
module led_brightness_control
  import led_pkg::*;
#(
  parameter int DUTY_SHIFT = DUTY_SHIFT_DEF
)
(
  input  wire logic                                  sys_clk,
  input  wire logic                                  arst_n,
  input  wire logic [NUM_BANKS-1:0]                  bank_enable,
  input  wire logic [NUM_BANKS-1:0][CODE_W-1:0]      bank_code,
  input  wire logic [NUM_BANKS-1:0][FS_W-1:0]        bank_full_scale,
  input  wire logic [NUM_BANKS-1:0]                  bank_linear,
  input  wire logic [NUM_BANKS-1:0]                  bank_pwm_en,
  input  wire logic [NUM_BANKS-1:0]                  bank_als_en,
  input  wire logic [NUM_BANKS-1:0]                  bank_third_set,
  input  wire logic [NUM_BANKS-1:0]                  bank_pattern_en,
  input  wire logic [NUM_BANKS-1:0][1:0]             bank_pattern_sel,
  input  wire logic [NUM_SINKS-1:0][1:0]             sink_bank_sel,
  input  wire logic [NUM_SINKS-1:0]                  sink_anode_cp,
  input  wire logic [SEL_W-1:0]                      startup_sel,
  input  wire logic [SEL_W-1:0]                      shutdown_sel,
  input  wire logic [SEL_W-1:0]                      ramp_up_sel,
  input  wire logic [SEL_W-1:0]                      ramp_down_sel,
  input  wire logic                                  pwm_in,
  input  wire logic                                  pwm_active_low,
  input  wire logic [NUM_PATTERNS-1:0]               pattern_level,
  input  wire logic                                  als_enable,
  input  wire logic [CODE_W-1:0]                     adc_code,
  input  wire logic                                  adc_valid,
  input  wire logic [NUM_BOUNDS-1:0][CODE_W-1:0]     zone_high,
  input  wire logic [NUM_BOUNDS-1:0][CODE_W-1:0]     zone_low,
  input  wire logic [NUM_ZONES-1:0][CODE_W-1:0]      primary_zone_target_set,
  input  wire logic [NUM_ZONES-1:0][CODE_W-1:0]      second_zone_target_set,
  input  wire logic [NUM_ZONES-1:0][CODE_W-1:0]      third_zone_target_set,
  input  wire logic [NUM_SINKS-1:0]                  sink_short_det,
  input  wire logic                                  short_fault_clr,
  output logic      [NUM_SINKS-1:0][FRAC_W-1:0]      sink_fraction,
  output logic      [NUM_SINKS-1:0][FS_W-1:0]        sink_full_scale,
  output logic      [NUM_SINKS-1:0]                  charge_pump_loop_sel,
  output logic                                       short_fault,
  output logic      [ZONE_W-1:0]                     als_zone,
  output logic      [CODE_W-1:0]                     pwm_duty
);

  localparam int DW = DUTY_SHIFT + CODE_W;
  localparam logic [DW-1:0] WIN_LAST = DW'((DUTY_FULL << DUTY_SHIFT) - 1);

  // =====================================================================
  // pwm duty measurement
  logic [DW-1:0]     win_reg;
  logic [DW-1:0]     win_next;
  logic [DW-1:0]     high_reg;
  logic [DW-1:0]     high_next;
  logic [CODE_W-1:0] duty_reg;
  logic [CODE_W-1:0] duty_next;

  wire               pwm_act  = pwm_in ^ pwm_active_low;
  wire               win_end  = win_reg == WIN_LAST;
  wire [DW-1:0]      high_sum = high_reg + DW'(pwm_act);

  // active cycles over 255 * 2^shift cycles give duty in 0..255
  assign win_next  = win_end ? '0 : win_reg + DW'(1);
  assign high_next = win_end ? '0 : high_sum;
  assign duty_next = win_end ? CODE_W'(high_sum >> DUTY_SHIFT)
                             : duty_reg;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      win_reg  <= '0;
      high_reg <= '0;
      duty_reg <= DUTY_RESET;
    end else begin
      win_reg  <= win_next;
      high_reg <= high_next;
      duty_reg <= duty_next;
    end
  end

  wire [FRAC_W-1:0] duty_scale = FRAC_W'({8'h00, duty_reg} * LIN_MULT);
  wire              duty_full  = duty_reg == DUTY_MAX;

  // =====================================================================
  // ambient light zone tracking
  logic [ZONE_W-1:0] zone_reg;
  logic [ZONE_W-1:0] zone_next;

  wire [1:0] up_idx   = zone_reg[1:0];
  wire [1:0] down_idx = 2'(zone_reg - ZONE_W'(1));
  // adc code is 8-bit with 0xff at 2 V, compared against the boundaries
  wire zone_up   = (zone_reg != ZONE_TOP) &&
                   (adc_code > zone_high[up_idx]);
  wire zone_down = (zone_reg != ZONE_RESET) &&
                   (adc_code < zone_low[down_idx]);

  // hysteresis: rise only over the high mark, fall only under the low
  assign zone_next = !als_enable ? ZONE_RESET :
                     !adc_valid ? zone_reg :
                     zone_up ? zone_reg + ZONE_W'(1) :
                     zone_down ? zone_reg - ZONE_W'(1) :
                     zone_reg;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      zone_reg <= ZONE_RESET;
    end else begin
      zone_reg <= zone_next;
    end
  end

  // =====================================================================
  // control banks
  logic [NUM_BANKS-1:0][FRAC_W-1:0] bank_frac;

  ramp_if rif [NUM_BANKS] ();

  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    wire [CODE_W-1:0]   als_tgt;
    wire [CODE_W-1:0]   code;
    wire [FRAC_W-1:0]   map_frac;
    wire [2*FRAC_W-1:0] prod;
    wire [FRAC_W-1:0]   pwm_frac;
    wire                blank;

    // five zones index one of three target sets
    if (b == 0) begin : g_primary
      assign als_tgt = primary_zone_target_set[zone_reg];
    end else begin : g_shared
      assign als_tgt = bank_third_set[b] ?
                       third_zone_target_set[zone_reg] :
                       second_zone_target_set[zone_reg];
    end

    assign rif[b].enable    = bank_enable[b];
    assign rif[b].target    = bank_als_en[b] ? als_tgt
                                             : bank_code[b];
    assign rif[b].start_sel = startup_sel;
    assign rif[b].stop_sel  = shutdown_sel;
    assign rif[b].up_sel    = ramp_up_sel;
    assign rif[b].down_sel  = ramp_down_sel;

    ramp_unit u_ramp (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .rif     (rif[b])
    );

    assign code     = rif[b].code;
    assign map_frac = bank_linear[b] ?
                      FRAC_W'({8'h00, code} * LIN_MULT) :
                      EXP_LUT[code];
    assign prod     = map_frac * duty_scale;
    assign pwm_frac = (!bank_pwm_en[b] || duty_full) ? map_frac
                      : prod[2*FRAC_W-1:FRAC_W];
    assign blank    = bank_pattern_en[b] &&
                      !pattern_level[bank_pattern_sel[b]];
    assign bank_frac[b] = (rif[b].active && !blank) ? pwm_frac
                                                     : FRAC_ZERO;
  end

  // =====================================================================
  // sink mapping and short detection
  logic [NUM_SINKS-1:0][FRAC_W-1:0] frac_reg;
  logic [NUM_SINKS-1:0][FS_W-1:0]   fs_reg;
  logic [NUM_SINKS-1:0]             loop_reg;
  logic [NUM_SINKS-1:0]             short_hit;
  logic                             fault_reg;
  logic                             fault_next;

  for (genvar s = 0; s < NUM_SINKS; s++) begin : g_sink
    wire [1:0] bk = sink_bank_sel[s];

    // only pump-fed sinks with current flowing can flag a short
    assign short_hit[s] = sink_anode_cp[s] && sink_short_det[s] &&
                          (frac_reg[s] != FRAC_ZERO);

    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        frac_reg[s] <= FRAC_ZERO;
        fs_reg[s]   <= '0;
        loop_reg[s] <= 1'b1;
      end else begin
        frac_reg[s] <= bank_frac[bk];
        fs_reg[s]   <= bank_full_scale[bk];
        loop_reg[s] <= sink_anode_cp[s];
      end
    end
  end

  // a new short wins over a clear in the same cycle
  assign fault_next = (|short_hit) || (fault_reg && !short_fault_clr);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fault_reg <= 1'b0;
    end else begin
      fault_reg <= fault_next;
    end
  end

  // =====================================================================
  // outputs
  assign sink_fraction        = frac_reg;
  assign sink_full_scale      = fs_reg;
  assign charge_pump_loop_sel = loop_reg;
  assign short_fault          = fault_reg;
  assign als_zone             = zone_reg;
  assign pwm_duty             = duty_reg;

endmodule : led_brightness_control
`default_nettype wire

/* File: tb/led_brightness_control_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module led_brightness_control_asserts
  import led_pkg::*;
#(
  parameter int DUTY_SHIFT = DUTY_SHIFT_DEF
)
(
  input wire logic                              sys_clk,
  input wire logic                              arst_n,
  input wire logic [NUM_BANKS-1:0][FS_W-1:0]    bank_full_scale,
  input wire logic [NUM_BANKS-1:0]              bank_pattern_en,
  input wire logic [NUM_BANKS-1:0][1:0]         bank_pattern_sel,
  input wire logic [NUM_SINKS-1:0][1:0]         sink_bank_sel,
  input wire logic [NUM_SINKS-1:0]              sink_anode_cp,
  input wire logic [NUM_PATTERNS-1:0]           pattern_level,
  input wire logic                              als_enable,
  input wire logic [CODE_W-1:0]                 adc_code,
  input wire logic                              adc_valid,
  input wire logic [NUM_BOUNDS-1:0][CODE_W-1:0] zone_high,
  input wire logic [NUM_BOUNDS-1:0][CODE_W-1:0] zone_low,
  input wire logic [NUM_SINKS-1:0]              sink_short_det,
  input wire logic                              short_fault_clr,
  input wire logic [NUM_SINKS-1:0][FRAC_W-1:0]  sink_fraction,
  input wire logic [NUM_SINKS-1:0][FS_W-1:0]    sink_full_scale,
  input wire logic [NUM_SINKS-1:0]              charge_pump_loop_sel,
  input wire logic                              short_fault,
  input wire logic [ZONE_W-1:0]                 als_zone,
  input wire logic [CODE_W-1:0]                 pwm_duty
);
  // ==================================================================
  // helper decode
  logic [NUM_SINKS-1:0] lit;
  logic                 fault_set, sample, go_up, go_down, gated;
  for (genvar i = 0; i < NUM_SINKS; i++) begin : g_lit
    assign lit[i] = sink_fraction[i] != FRAC_ZERO;
  end
  assign fault_set = |(sink_anode_cp & sink_short_det & lit);
  assign sample = adc_valid && als_enable;
  assign go_up = sample && als_zone < ZONE_TOP &&
                 adc_code > zone_high[als_zone[1:0]];
  assign go_down = sample && !go_up && als_zone != ZONE_RESET &&
                   adc_code < zone_low[2'(als_zone - 3'h1)];
  assign gated = bank_pattern_en[sink_bank_sel[0]] &&
                 !pattern_level[bank_pattern_sel[sink_bank_sel[0]]];
  // ==================================================================
  // properties
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence s_up;
    ##1 als_zone == $past(als_zone) + 3'h1;
  endsequence
  sequence s_down;
    ##1 als_zone == $past(als_zone) - 3'h1;
  endsequence
  zone_up_a: assert property (go_up |-> s_up)
    else $error("zone did not rise");
  zone_down_a: assert property (go_down |-> s_down)
    else $error("zone did not fall");
  zone_hold_a: assert property (als_enable && !go_up && !go_down
    |=> $stable(als_zone)) else $error("zone moved without cause");
  zone_range_a: assert property (als_zone <= ZONE_TOP)
    else $error("zone out of range");
  zone_off_a: assert property (!als_enable [*2] |->
    als_zone == ZONE_RESET) else $error("zone not held at zero");
  fault_set_a: assert property (fault_set |=> short_fault)
    else $error("short fault not raised");
  fault_keep_a: assert property (short_fault && !short_fault_clr
    |=> short_fault) else $error("short fault dropped");
  fault_clear_a: assert property (short_fault_clr && !fault_set |=>
    !short_fault) else $error("short fault not cleared");
  fault_cause_a: assert property ($rose(short_fault) |->
    $past(fault_set)) else $error("short fault without cause");
  loop_sel_a: assert property ($stable(sink_anode_cp) [*2] |->
    charge_pump_loop_sel == sink_anode_cp) else $error("loop select");
  pattern_gate_a: assert property (gated [*3] |->
    sink_fraction[0] == FRAC_ZERO) else $error("pattern did not gate");
  duty_hold_a: assert property ($changed(pwm_duty) |=>
    $stable(pwm_duty) [*8]) else $error("duty changed mid window");
  for (genvar i = 0; i < NUM_SINKS; i++) begin : g_fs
    fs_map_a: assert property ($stable(sink_bank_sel) &&
      $stable(bank_full_scale) |=> sink_full_scale[i] ==
      $past(bank_full_scale[sink_bank_sel[i]])) else $error("full scale map");
  end
endmodule : led_brightness_control_asserts
bind led_brightness_control led_brightness_control_asserts
  #(.DUTY_SHIFT(DUTY_SHIFT)) u_asserts (.sys_clk, .arst_n,
  .bank_full_scale, .bank_pattern_en, .bank_pattern_sel, .sink_bank_sel,
  .sink_anode_cp, .pattern_level, .als_enable, .adc_code, .adc_valid,
  .zone_high, .zone_low, .sink_short_det, .short_fault_clr,
  .sink_fraction, .sink_full_scale, .charge_pump_loop_sel, .short_fault,
  .als_zone, .pwm_duty);
`default_nettype wire

/* File: tb/pwm_host.sv */
`timescale 1ns/10ps
`default_nettype none
module pwm_host #(
  parameter int PERIOD = 204
)
(
  input  wire logic        sys_clk,
  input  wire logic [15:0] high_cycles,
  output var  logic        pwm_in
);
  int cnt = 0;
  // period of 204 cycles keeps the input near 98 kHz
  always @(posedge sys_clk) begin
    #1;
    cnt = (cnt + 1) % PERIOD;
    pwm_in = cnt < high_cycles;
  end
endmodule : pwm_host
`default_nettype wire

/* File: tb/tb_led_brightness_control.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_led_brightness_control;
  import led_pkg::*;
  typedef struct packed { logic [7:0] code; logic lin; } row_s;
  logic            sys_clk = 1'b0;
  logic            arst_n = 1'b0;
  logic [3:0]      bank_enable, bank_linear, bank_pwm_en, bank_als_en;
  logic [3:0]      bank_third_set, bank_pattern_en, pattern_level;
  logic [3:0][7:0] bank_code, zone_high, zone_low;
  logic [3:0][4:0] bank_full_scale;
  logic [3:0][1:0] bank_pattern_sel;
  logic [4:0][1:0] sink_bank_sel;
  logic [4:0]      sink_anode_cp, sink_short_det, charge_pump_loop_sel;
  logic [2:0]      startup_sel, shutdown_sel, ramp_up_sel, ramp_down_sel;
  logic [2:0]      als_zone;
  logic            pwm_in, pwm_active_low, als_enable, adc_valid;
  logic            short_fault_clr, short_fault;
  logic [7:0]      adc_code, pwm_duty;
  logic [4:0][7:0] primary_zone_target_set, second_zone_target_set;
  logic [4:0][7:0] third_zone_target_set;
  logic [4:0][15:0] sink_fraction;
  logic [4:0][4:0] sink_full_scale;
  logic [15:0]     pwm_high = 16'd204;
  int              errors = 0;
  int              checks = 0;
  row_s rows [8] = '{'{8'h00, 1'b1}, '{8'h01, 1'b1}, '{8'h80, 1'b1},
    '{8'hff, 1'b1}, '{8'h00, 1'b0}, '{8'h10, 1'b0}, '{8'h7f, 1'b0},
    '{8'hff, 1'b0}};
  int   ph [3] = '{51, 51, 204};
  logic pl [3] = '{1'b0, 1'b1, 1'b0};
  int   pd [3] = '{63, 191, 255};
  logic [7:0] sa [13] = '{8'h40, 8'h41, 8'h30, 8'h2f, 8'hff, 8'hff, 8'h80,
    8'h6f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00};
  int         sz [13] = '{0, 1, 1, 0, 1, 2, 2, 1, 2, 3, 4, 4, 3};

  always #25 sys_clk = ~sys_clk;

  led_brightness_control #(.DUTY_SHIFT(3)) u_dut (.sys_clk, .arst_n,
    .bank_enable, .bank_code, .bank_full_scale, .bank_linear, .bank_pwm_en,
    .bank_als_en, .bank_third_set, .bank_pattern_en, .bank_pattern_sel,
    .sink_bank_sel, .sink_anode_cp, .startup_sel, .shutdown_sel,
    .ramp_up_sel, .ramp_down_sel, .pwm_in, .pwm_active_low, .pattern_level,
    .als_enable, .adc_code, .adc_valid, .zone_high, .zone_low,
    .primary_zone_target_set, .second_zone_target_set,
    .third_zone_target_set, .sink_short_det, .short_fault_clr,
    .sink_fraction, .sink_full_scale, .charge_pump_loop_sel, .short_fault,
    .als_zone, .pwm_duty);
  pwm_host u_host (.sys_clk, .high_cycles(pwm_high), .pwm_in);

  // ==================================================================
  // helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : wait_cyc
  function automatic logic [15:0] lf(input int c, input logic lin);
    if (lin) return 16'(c * 257);
    return 16'($rtoi(65535.0 * (0.862 ** (46.6 * (c + 1) / 5.5))));
  endfunction : lf
  task automatic ramp_chk(input logic [15:0] lo, hi, fin);
    wait_cyc(50);
    chk(sink_fraction[1] > lo && sink_fraction[1] < hi, 1'b1);
    wait_cyc(100);
    chk(sink_fraction[1], fin);
  endtask : ramp_chk
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict

  // ==================================================================
  // tests
  initial begin
    {bank_enable, bank_linear, bank_pwm_en, bank_als_en, bank_third_set,
     bank_pattern_en, bank_code, bank_pattern_sel, sink_short_det} = '0;
    {startup_sel, shutdown_sel, ramp_up_sel, ramp_down_sel} = '0;
    {pwm_active_low, als_enable, adc_valid, short_fault_clr} = '0;
    adc_code = 8'h00;
    pattern_level = 4'hf;
    sink_anode_cp = 5'h1f;
    bank_full_scale = {5'h18, 5'h11, 5'h0a, 5'h03};
    sink_bank_sel = {2'h0, 2'h3, 2'h2, 2'h1, 2'h0};
    zone_high = {8'he0, 8'hc0, 8'h80, 8'h40};
    zone_low = {8'hd0, 8'hb0, 8'h70, 8'h30};
    primary_zone_target_set = {8'h50, 8'h40, 8'h30, 8'h20, 8'h10};
    second_zone_target_set = {8'ha0, 8'h80, 8'h60, 8'h40, 8'h20};
    third_zone_target_set = {8'hf0, 8'hc0, 8'h90, 8'h60, 8'h30};
    wait_cyc(19);
    for (int s = 0; s < 5; s++) chk(sink_fraction[s], 0);
    chk({charge_pump_loop_sel, short_fault}, 6'h3e);
    chk({als_zone, pwm_duty}, 11'h0ff);
    chk(sink_full_scale, 25'h0);
    wait_cyc(1);
    arst_n = 1'b1;
    wait_cyc(2);
    bank_enable[0] = 1'b1;
    for (int r = 0; r < 8; r++) begin
      bank_code[0] = rows[r].code;
      bank_linear[0] = rows[r].lin;
      wait_cyc(300);
      chk(sink_fraction[0],
          lf(rows[r].code, rows[r].lin));
      chk(sink_fraction[4], lf(rows[r].code, rows[r].lin));
    end
    for (int s = 0; s < 5; s++) begin
      chk(sink_full_scale[s], (s % 4) * 7 + 3);
    end
    sink_bank_sel[4] = 2'h1;
    wait_cyc(3);
    chk({sink_full_scale[4], sink_fraction[4]}, {5'h0a, 16'h0});
    {startup_sel, shutdown_sel, ramp_up_sel} = {3'h1, 3'h1, 3'h1};
    {bank_linear[1], bank_code[1], bank_enable[1]} = {1'b1, 8'h05, 1'b1};
    ramp_chk(0, lf(5, 1), lf(5, 1));
    bank_code[1] = 8'h0a;
    ramp_chk(lf(5, 1), lf(10, 1), lf(10, 1));
    {ramp_down_sel, bank_code[1]} = {3'h1, 8'h05};
    ramp_chk(lf(5, 1), lf(10, 1), lf(5, 1));
    bank_enable[1] = 1'b0;
    ramp_chk(0, lf(5, 1), 0);
    {bank_linear[0], bank_pwm_en[0]} = 2'b11;
    for (int p = 0; p < 3; p++) begin
      {pwm_high, pwm_active_low} = {16'(ph[p]), pl[p]};
      wait_cyc(5000);
      chk(pwm_duty, pd[p]);
      chk(sink_fraction[0], p == 2 ? 16'hffff :
        16'(longint'(pd[p]) * 65535 * 257 >> 16));
    end
    {startup_sel, shutdown_sel, ramp_up_sel, ramp_down_sel} = '0;
    {bank_pwm_en, bank_linear, bank_als_en} = {4'h0, 4'hf, 4'h7};
    {bank_third_set, bank_enable, als_enable} = {4'h2, 4'h7, 1'b1};
    for (int z = 0; z < 13; z++) begin
      {adc_code, adc_valid} = {sa[z], 1'b1};
      wait_cyc(1);
      adc_valid = 1'b0;
      wait_cyc(1);
      chk(als_zone, sz[z]);
    end
    wait_cyc(300);
    chk(sink_fraction[0], lf(8'h40, 1));
    chk(sink_fraction[1], lf(8'hc0, 1));
    chk(sink_fraction[2], lf(8'h80, 1));
    {als_enable, bank_als_en} = 5'h0;
    wait_cyc(300);
    chk(als_zone, 0);
    {bank_pattern_en[0], bank_pattern_sel[0], pattern_level} = 7'h6b;
    wait_cyc(4);
    chk(sink_fraction[0], 0);
    pattern_level = 4'hf;
    wait_cyc(5);
    chk(sink_fraction[0], 16'hffff);
    sink_anode_cp = 5'h15;
    wait_cyc(2);
    chk(charge_pump_loop_sel, 5'h15);
    sink_short_det = 5'h02;
    wait_cyc(3);
    chk(short_fault, 1'b0);
    {sink_short_det, short_fault_clr} = {5'h03, 1'b0};
    wait_cyc(2);
    short_fault_clr = 1'b1;
    wait_cyc(2);
    chk(short_fault, 1'b1);
    sink_short_det = 5'h00;
    wait_cyc(2);
    chk(short_fault, 1'b0);
    print_verdict();
  end

  initial begin
    #2_000_000;
    errors++;
    print_verdict();
  end
endmodule : tb_led_brightness_control
`default_nettype wire
